// ### verilog/bzo_pkg.sv
package bzo_pkg;

  // ****************************************************
  // Pin arrangements chosen by static configuration
  // ****************************************************
  typedef enum logic [1:0]
  {
    BZO_MODE_PORT,
    BZO_MODE_PAIR,
    BZO_MODE_SINGLE
  } bzo_mode_t;

  // ****************************************************
  // Buzzer source clock choices
  // ****************************************************
  typedef enum logic [1:0]
  {
    BZO_SRC_CRYSTAL,
    BZO_SRC_RC,
    BZO_SRC_CORE_DIV4
  } bzo_src_t;

  // ****************************************************
  // Divider layout
  // ****************************************************
  localparam int unsigned BZO_RATIO_EXP_MIN = 2;
  localparam int unsigned BZO_RATIO_EXP_MAX = 9;
  localparam int unsigned BZO_DIV_W         = 8;
  localparam logic [2:0]  BZO_RATIO_SEL_MAX = 3'h7;
  localparam logic [1:0]  BZO_CORE_DIV_LAST = 2'h1;
  localparam logic [BZO_DIV_W-1:0] BZO_DIV_RST = 8'h00;

  // Bit positions in the synchroniser registers
  localparam int unsigned BZO_BIT_ZERO = 0;
  localparam int unsigned BZO_BIT_ONE  = 1;

endpackage

// ### verilog/bzo_buzzer.sv
`timescale 1ns/1ps
module bzo_buzzer
  import bzo_pkg::*;
#(
  // Static configuration, no software path reaches these
  parameter bzo_mode_t   CFG_MODE      = BZO_MODE_PAIR,
  parameter bzo_src_t    CFG_SRC       = BZO_SRC_CORE_DIV4,
  parameter logic [2:0]  CFG_RATIO_SEL = 3'h0
)
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic clk_en,
  input  wire logic low_speed_crystal_osc,
  input  wire logic low_speed_rc_osc,
  input  wire logic dir_ctrl_bit_zero,
  input  wire logic dir_ctrl_bit_one,
  input  wire logic port_out_bit_zero,
  input  wire logic port_out_bit_one,
  input  wire logic shared_pin_zero_i,
  input  wire logic shared_pin_one_i,
  output logic      shared_pin_zero_o,
  output logic      shared_pin_zero_oe_n,
  output logic      shared_pin_one_o,
  output logic      shared_pin_one_oe_n,
  output logic      pin_zero_in_q,
  output logic      pin_one_in_q,
  output logic      buzzer_out
);

  // ****************************************************
  // Pin and oscillator synchronisers
  // ****************************************************
  logic [1:0] osc_sync1_q;
  logic [1:0] osc_sync2_q;
  logic [1:0] pin_sync1_q;
  logic [1:0] pin_sync2_q;

  // Oscillators are foreign to ref_clk: two flops each, bit one is RC
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_sync1_q <= 2'h0;
      osc_sync2_q <= 2'h0;
    end
    else if (clk_en)
    begin
      osc_sync1_q <= {low_speed_rc_osc, low_speed_crystal_osc};
      osc_sync2_q <= osc_sync1_q;
    end
  end

  // Pin levels are foreign too; only the second flop is read below
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_sync1_q <= 2'h0;
      pin_sync2_q <= 2'h0;
    end
    else if (clk_en)
    begin
      pin_sync1_q <= {shared_pin_one_i, shared_pin_zero_i};
      pin_sync2_q <= pin_sync1_q;
    end
  end

  // ****************************************************
  // Source clock tick
  // ****************************************************
  logic       osc_prev_q;
  logic [1:0] core_div_q;
  logic       src_tick;
  logic       osc_sel;

  always_comb
  begin
    osc_sel = (CFG_SRC == BZO_SRC_RC) ? osc_sync2_q[BZO_BIT_ONE] : osc_sync2_q[BZO_BIT_ZERO];
    if (CFG_SRC == BZO_SRC_CORE_DIV4)
    begin
      src_tick = (core_div_q == BZO_CORE_DIV_LAST);
    end
    else
    begin
      src_tick = osc_sel & ~osc_prev_q;
    end
  end

  // Edge history of the chosen slow oscillator; it freezes with the
  // synchronisers, so a pause of clk_en neither loses nor adds an edge
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      osc_prev_q <= osc_sel;
    end
  end

  // Core divide by four; slow oscillators are edge sampled, so they
  // must run well below a quarter of ref_clk to be seen cleanly
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_div_q <= 2'h0;
    end
    else if (clk_en)
    begin
      core_div_q <= core_div_q + 2'h1;
    end
  end

  // ****************************************************
  // Power of two divider
  // ****************************************************
  logic [BZO_DIV_W-1:0] div_q;
  logic                 div_wrap;
  logic [BZO_DIV_W-1:0] half_mask_c;

  // Half period mask for a ratio of 2^(sel+2); shift kept four bits wide
  function automatic logic [BZO_DIV_W-1:0] half_mask(input logic [2:0] sel);
    logic [BZO_DIV_W:0] one_hot;
    one_hot   = {{BZO_DIV_W{1'b0}}, 1'b1} << ({1'b0, sel} + 4'h1);
    half_mask = one_hot[BZO_DIV_W-1:0] - {{(BZO_DIV_W-1){1'b0}}, 1'b1};
  endfunction

  // Mask is fixed by configuration, so this folds to a constant
  assign half_mask_c = half_mask(CFG_RATIO_SEL);

  assign div_wrap = src_tick && ((div_q & half_mask_c) == half_mask_c);

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q <= BZO_DIV_RST;
    end
    else if (clk_en && src_tick)
    begin
      div_q <= div_wrap ? BZO_DIV_RST : div_q + {{(BZO_DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      buzzer_out <= 1'b0;
    end
    else if (clk_en && div_wrap)
    begin
      buzzer_out <= ~buzzer_out;
    end
  end

  // ****************************************************
  // Pin function mux
  // ****************************************************
  logic zero_d;
  logic one_d;
  logic zero_oe_n_d;
  logic one_oe_n_d;
  logic wave_next;
  logic one_is_wave;

  // Buzzer output passes only while its enable bit is one; shared by
  // both pins so their gating cannot drift apart
  function automatic logic gate_wave(input logic enable, input logic wave);
    gate_wave = enable & wave;
  endfunction

  // Outputs are registered, so use the wave value about to be stored
  assign wave_next = div_wrap ? ~buzzer_out : buzzer_out;

  // The inverted wave needs pin zero to be an output; with pin zero an
  // input, pin one falls back to its own data bit like any port pin
  assign one_is_wave = (CFG_MODE == BZO_MODE_PAIR) && !dir_ctrl_bit_zero;

  always_comb
  begin
    zero_oe_n_d = dir_ctrl_bit_zero;
    one_oe_n_d  = dir_ctrl_bit_one;
  end

  always_comb
  begin
    zero_d = port_out_bit_zero;
    case (CFG_MODE)
      BZO_MODE_PAIR:
      begin
        zero_d = gate_wave(port_out_bit_zero, wave_next);
      end
      BZO_MODE_SINGLE:
      begin
        zero_d = gate_wave(port_out_bit_zero, wave_next);
      end
      BZO_MODE_PORT:
      begin
        zero_d = port_out_bit_zero;
      end
      default:
      begin
        zero_d = port_out_bit_zero;
      end
    endcase
  end

  // Pin one follows the wave only in the pair arrangement
  always_comb
  begin
    if (one_is_wave)
    begin
      one_d = gate_wave(port_out_bit_zero, ~wave_next);
    end
    else
    begin
      one_d = port_out_bit_one;
    end
  end

  // ****************************************************
  // Pin drive registers
  // ****************************************************
  // Reset releases both pins, so nothing is driven before software acts
  // Pin zero drive and enable
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shared_pin_zero_o    <= 1'b0;
      shared_pin_zero_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      shared_pin_zero_o    <= zero_d;
      shared_pin_zero_oe_n <= zero_oe_n_d;
    end
  end

  // Pin one drive and enable
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shared_pin_one_o    <= 1'b0;
      shared_pin_one_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      shared_pin_one_o    <= one_d;
      shared_pin_one_oe_n <= one_oe_n_d;
    end
  end

  // Third flop of the input path: a clean registered pin level, read
  // whatever the direction so software can watch its own drive
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_zero_in_q <= 1'b0;
      pin_one_in_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_zero_in_q <= pin_sync2_q[BZO_BIT_ZERO];
      pin_one_in_q  <= pin_sync2_q[BZO_BIT_ONE];
    end
  end

endmodule // bzo_buzzer

// ### verification/bzo_buzzer_properties.sv
`timescale 1ns/1ps
// ****
// Pin checks for all three arrangements; wave lengths only for ratio 4 on core clock / 4
// ****
module bzo_buzzer_properties
  import bzo_pkg::*;
#(
  parameter bzo_mode_t  CFG_MODE      = BZO_MODE_PAIR,
  parameter bzo_src_t   CFG_SRC       = BZO_SRC_CORE_DIV4,
  parameter logic [2:0] CFG_RATIO_SEL = 3'h0
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic dir_ctrl_bit_zero,
  input wire logic dir_ctrl_bit_one,
  input wire logic port_out_bit_zero,
  input wire logic port_out_bit_one,
  input wire logic shared_pin_zero_i,
  input wire logic shared_pin_one_i,
  input wire logic shared_pin_zero_o,
  input wire logic shared_pin_zero_oe_n,
  input wire logic shared_pin_one_o,
  input wire logic shared_pin_one_oe_n,
  input wire logic pin_zero_in_q,
  input wire logic pin_one_in_q,
  input wire logic buzzer_out
);
  // Half lengths below hold only for ratio 4 on core / 4
  localparam bit FAST_WAVE = (CFG_SRC == BZO_SRC_CORE_DIV4) && (CFG_RATIO_SEL == 3'h0);
  localparam bit IS_PORT = (CFG_MODE == BZO_MODE_PORT);
  localparam bit IS_PAIR = (CFG_MODE == BZO_MODE_PAIR);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Ratio 4 on core / 4 gives eight cycles per half
  sequence s_high; buzzer_out [*8] ##1 !buzzer_out; endsequence
  sequence s_low; !buzzer_out [*8] ##1 buzzer_out; endsequence
  a_pair_gate: assert property (
    shared_pin_zero_o == (IS_PORT ? $past(port_out_bit_zero)
                          : ($past(port_out_bit_zero) & buzzer_out))) else $error("pin zero gate");
  a_pair_inverse: assert property (
    shared_pin_one_o == ((IS_PAIR && !$past(dir_ctrl_bit_zero))
                         ? ($past(port_out_bit_zero) & !buzzer_out) : $past(port_out_bit_one)))
    else $error("pin one inverse");
  a_dir_zero: assert property ($past(arst_n) |->
    shared_pin_zero_oe_n == $past(dir_ctrl_bit_zero)) else $error("pin zero direction");
  a_dir_one: assert property ($past(arst_n) |->
    shared_pin_one_oe_n == $past(dir_ctrl_bit_one)) else $error("pin one direction");
  a_wave_high: assert property (FAST_WAVE && $rose(buzzer_out) |-> s_high)
    else $error("high half length");
  a_wave_low: assert property (FAST_WAVE && $fell(buzzer_out) |-> s_low)
    else $error("low half length");
  a_sync_zero: assert property ($past(arst_n, 3) |->
    pin_zero_in_q == $past(shared_pin_zero_i, 3)) else $error("pin zero input");
  a_sync_one: assert property ($past(arst_n, 3) |->
    pin_one_in_q == $past(shared_pin_one_i, 3)) else $error("pin one input");
endmodule // bzo_buzzer_properties
bind bzo_buzzer bzo_buzzer_properties #(.CFG_MODE(CFG_MODE), .CFG_SRC(CFG_SRC),
  .CFG_RATIO_SEL(CFG_RATIO_SEL)) u_props (.*);

// ### verification/bzo_load.sv
`timescale 1ns/1ps
// ****
// Outside load on the two shared pins
// ****
module bzo_load (
  input  wire logic zo,
  input  wire logic zoe,
  input  wire logic oo,
  input  wire logic ooe,
  input  wire logic zx,
  input  wire logic ox,
  output logic      zi,
  output logic      oi
);
  // A released pin shows what the outside drives, never a stale value
  assign zi = zoe ? zx : zo;
  assign oi = ooe ? ox : oo;
endmodule // bzo_load

// ### verification/testbench.sv
`timescale 1ns/1ps
// ****
// Random pin control plus a wave length probe
// ****
module testbench
  import bzo_pkg::*;
;
  logic ref_clk = 0, arst_n = 0, d0 = 1, d1 = 1, p0 = 0, p1 = 0, x0 = 0, x1 = 0;
  logic xt = 0, rc = 0, seen;
  logic zo, zoe, oo, ooe, pz, po, sz, so, pzp, pop, pb;
  logic [7:0] r = 8'h50;
  int fails = 0, n_compared = 0, k;
  bzo_buzzer dut (.ref_clk, .arst_n, .clk_en(1'b1), .low_speed_crystal_osc(1'b0),
    .low_speed_rc_osc(1'b0), .dir_ctrl_bit_zero(d0), .dir_ctrl_bit_one(d1),
    .port_out_bit_zero(p0), .port_out_bit_one(p1), .shared_pin_zero_i(pz),
    .shared_pin_one_i(po), .shared_pin_zero_o(zo), .shared_pin_zero_oe_n(zoe),
    .shared_pin_one_o(oo), .shared_pin_one_oe_n(ooe), .pin_zero_in_q(),
    .pin_one_in_q(), .buzzer_out());
  bzo_load ld (.zo, .zoe, .oo, .ooe, .zx(x0), .ox(x1), .zi(pz), .oi(po));
  // Single pin on the crystal, ratio 8; port arrangement on RC, ratio 512
  bzo_buzzer #(.CFG_MODE(BZO_MODE_SINGLE), .CFG_SRC(BZO_SRC_CRYSTAL), .CFG_RATIO_SEL(3'h1))
    dut_single (.ref_clk, .arst_n, .clk_en(1'b1), .low_speed_crystal_osc(xt),
    .low_speed_rc_osc(rc), .dir_ctrl_bit_zero(d0), .dir_ctrl_bit_one(d1),
    .port_out_bit_zero(p0), .port_out_bit_one(p1), .shared_pin_zero_i(x0),
    .shared_pin_one_i(x1), .shared_pin_zero_o(sz), .shared_pin_zero_oe_n(),
    .shared_pin_one_o(so), .shared_pin_one_oe_n(), .pin_zero_in_q(),
    .pin_one_in_q(), .buzzer_out());
  bzo_buzzer #(.CFG_MODE(BZO_MODE_PORT), .CFG_SRC(BZO_SRC_RC), .CFG_RATIO_SEL(3'h7))
    dut_port (.ref_clk, .arst_n, .clk_en(1'b1), .low_speed_crystal_osc(xt),
    .low_speed_rc_osc(rc), .dir_ctrl_bit_zero(d0), .dir_ctrl_bit_one(d1),
    .port_out_bit_zero(p0), .port_out_bit_one(p1), .shared_pin_zero_i(x0),
    .shared_pin_one_i(x1), .shared_pin_zero_o(pzp), .shared_pin_zero_oe_n(),
    .shared_pin_one_o(pop), .shared_pin_one_oe_n(), .pin_zero_in_q(),
    .pin_one_in_q(), .buzzer_out(pb));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask
  // Data bit one toggles on every step; the pair must not notice
  task step;
    @(negedge ref_clk);
    p1 = ~p1;
    k++;
  endtask
  // Pin one shows its own data bit while pin zero is an input; otherwise
  // the pair differs exactly when data bit zero enables the wave
  function automatic logic exp_one(input logic dz, input logic pz0, input logic pone);
    return dz ? pone : pz0;
  endfunction
  // Wave under measurement: pair pin zero, single pin zero, port raw wave
  function automatic logic pin(input int w);
    return (w == 0) ? zo : ((w == 1) ? sz : pb);
  endfunction
  // Count both halves of one wave in ref_clk cycles
  task halves(input int w, input int e);
    k = 0;
    while (pin(w) !== 1'b0 && k < 9000) step;
    while (pin(w) !== 1'b1 && k < 9000) step;
    k = 0;
    while (pin(w) === 1'b1 && k < 5000) step;
    chk(k[15:0], e[15:0]);
    k = 0;
    while (pin(w) === 1'b0 && k < 5000) step;
    chk(k[15:0], e[15:0]);
  endtask
  task wrap_up;
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Slow sources: crystal 20 cycles, RC 8 cycles per period
  always #50 xt = ~xt;
  always #20 rc = ~rc;
  // Hang guard, several times the expected run
  initial
  begin
    #200000;
    fails++;
    wrap_up;
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1;
    repeat (300)
    begin
      @(negedge ref_clk);
      r = lfsr(r);
      {d0, d1, p0, p1, x0, x1} = r[5:0];
      @(negedge ref_clk);
      chk({14'h0, zoe, ooe}, {14'h0, d0, d1});
      seen = d0 ? oo : (p0 ? zo ^ oo : zo | oo);
      chk({15'h0, seen}, {15'h0, exp_one(d0, p0, p1)});
      chk({14'h0, sz & ~p0, so}, {14'h0, 1'b0, p1});
      chk({14'h0, pzp, pop}, {14'h0, p0, p1});
    end
    @(negedge ref_clk);
    {d0, d1, p0} = 3'b001;
    halves(0, 8);
    halves(1, 80);
    halves(2, 2048);
    wrap_up;
  end
endmodule // testbench
